// ==== src/mbsrv_pkg.sv ====
// Constants, carrier types and state types of the request server
// Overview of operation
// RQ1 - Echo transaction identifier into every response
// RQ2 - Echo protocol identifier, zero means this protocol
// RQ3 - Response length recomputed: bytes after length field
// RQ4 - Echo unit identifier into every response
// RQ5 - Serve codes 03, 06 and 16
// RQ6 - Serve device identification, function 43/14
// RQ7 - Non-adjacent read 100/4 reserved for later revision
// RQ8 - Clean, executable request gets normal response
// RQ9 - Erroneous or missing request gets no response
// RQ10 - Client times out unanswered requests
// RQ11 - Clean but unexecutable request gets exception response
// RQ12 - Exception: unit, code, exception code, check
// RQ13 - Exception function code is request code plus 128
// RQ14 - Code 01: function not permitted
// RQ15 - Code 02: data address not permitted
// RQ16 - Code 03: data value not permitted
// RQ17 - Code 04: unrecoverable internal failure
// RQ18 - Code 06: busy with another command
// RQ19 - Client resends busy request once server free
// RQ20 - Variables read-only, read/write, write-only; protect read-only
// RQ21 - One transaction at a time, others answered busy; the code queues only one busy answer and drops later frames unanswered
package mbsrv_pkg;

   // Variable store: words below RO_END are read-only, from WO_BASE up write-only
   localparam int AW = 6;
   localparam int WORDS = 64;
   localparam logic [15:0] WORDS16 = 16'h0040;
   localparam logic [15:0] RO_END = 16'h0010;
   localparam logic [15:0] WO_BASE = 16'h0030;

   // Function and sub-function codes
   localparam logic [7:0] FC_RD = 8'h03;
   localparam logic [7:0] FC_WR1 = 8'h06;
   localparam logic [7:0] FC_WRN = 8'h10;
   localparam logic [7:0] FC_DID = 8'h2B;
   localparam logic [7:0] SUB_DID = 8'h0E;
   localparam logic [7:0] FC_NADJ = 8'h64;
   localparam logic [7:0] EXC_FLAG = 8'h80;

   // Exception codes
   localparam logic [7:0] EX_NONE = 8'h00;
   localparam logic [7:0] EX_FUNC = 8'h01;
   localparam logic [7:0] EX_ADDR = 8'h02;
   localparam logic [7:0] EX_VALUE = 8'h03;
   localparam logic [7:0] EX_FAIL = 8'h04;
   localparam logic [7:0] EX_BUSY = 8'h06;

   // Quantity limits and identification read codes
   localparam logic [15:0] RD_MAX = 16'h007D;
   localparam logic [15:0] WRN_MAX = 16'h007B;
   localparam logic [7:0] DID_CODE_MAX = 8'h04;

   // Byte positions within a frame, header first
   localparam logic [8:0] IX_TID_H = 9'h000;
   localparam logic [8:0] IX_TID_L = 9'h001;
   localparam logic [8:0] IX_PID_H = 9'h002;
   localparam logic [8:0] IX_PID_L = 9'h003;
   localparam logic [8:0] IX_LEN_H = 9'h004;
   localparam logic [8:0] IX_LEN_L = 9'h005;
   localparam logic [8:0] IX_UID = 9'h006;
   localparam logic [8:0] IX_FC = 9'h007;
   localparam logic [8:0] IX_A_H = 9'h008;
   localparam logic [8:0] IX_A_L = 9'h009;
   localparam logic [8:0] IX_B_H = 9'h00A;
   localparam logic [8:0] IX_B_L = 9'h00B;
   localparam logic [8:0] IX_BC = 9'h00C;
   localparam logic [8:0] IX_DATA = 9'h00D;
   localparam logic [8:0] IX_MAX = 9'h1FF;
   localparam logic [15:0] LEN_OFS = 16'h0005;

   // Response layout
   localparam logic [7:0] PDU_EXC = 8'h04;
   localparam logic [7:0] PDU_ECHO = 8'h05;
   localparam logic [7:0] PDU_DID = 8'h0A;
   localparam logic [7:0] PDU_RD_FIX = 8'h02;
   localparam logic [7:0] DID_CONF = 8'h01;
   localparam logic [7:0] DID_NOBJ = 8'h01;
   localparam logic [7:0] DID_OBJ0 = 8'h00;
   localparam logic [7:0] DID_OBJLEN = 8'h01;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;

   typedef enum logic {S_RX = 1'b0, S_TX = 1'b1} mbsrv_st_type;
   typedef enum logic [1:0] {M_NORM = 2'b00, M_BUSY = 2'b01, M_DROP = 2'b10} mbsrv_rxm_type;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
      logic err;
   } mbsrv_rx_type;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
   } mbsrv_tx_type;

   typedef struct packed {
      mbsrv_st_type st;
      logic [1:0] flt;
      logic rx_on;
      logic rx_bad;
      mbsrv_rxm_type rxm;
      logic [8:0] rx_idx;
      logic [15:0] tid;
      logic [15:0] pid;
      logic [15:0] len;
      logic [7:0] uid;
      logic [7:0] fc;
      logic [15:0] a;
      logic [15:0] b;
      logic [7:0] bc;
      logic [7:0] hold;
      logic wok;
      logic [15:0] b_tid;
      logic [15:0] b_pid;
      logic [7:0] b_uid;
      logic [7:0] b_fc;
      logic b_pend;
      logic [7:0] exc;
      logic [7:0] pdu_len;
      logic [8:0] tx_idx;
      logic tx_wait;
      logic [15:0] crc;
      mbsrv_tx_type tx;
      logic we;
      logic [AW-1:0] waddr;
      logic [15:0] wdata;
   } mbsrv_state_type;

   typedef struct packed {
      logic [WORDS-1:0][15:0] mem;
      logic [15:0] rd;
   } mbsrv_mem_state_type;

endpackage

// ==== src/mbsrv_mem.sv ====
// Word store for the server variables, registered read port
`timescale 1ns/10ps
`default_nettype none
module mbsrv_mem
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Write port
   input wire logic we_i,
   input wire logic [mbsrv_pkg::AW-1:0] waddr_i,
   input wire logic [15:0] wdata_i,
   // Read port, data one cycle after address
   input wire logic [mbsrv_pkg::AW-1:0] raddr_i,
   output logic [15:0] rdata_o
);

   mbsrv_pkg::mbsrv_mem_state_type q;
   mbsrv_pkg::mbsrv_mem_state_type d;

   always_comb
   begin
      d = q;
      d.rd = q.mem[raddr_i];
      if (we_i)
      begin
         d.mem[waddr_i] = wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign rdata_o = q.rd;

endmodule
`default_nettype wire

// ==== src/mbsrv_top.sv ====
// Request server: frame parser, executor and response builder
`timescale 1ns/10ps
`default_nettype none
module mbsrv_top
#(
   // Arbitrary identification byte returned by device identification
   parameter logic [7:0] ID_CODE = 8'h5A
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Received request bytes from the transport, same clock
   input wire mbsrv_pkg::mbsrv_rx_type rx_i,
   // Response bytes to the transport
   output var mbsrv_pkg::mbsrv_tx_type tx_o,
   input wire logic tx_ready_i,
   // Unrecoverable internal fault, asynchronous level
   input wire logic fault_i
);

   mbsrv_pkg::mbsrv_state_type q;
   mbsrv_pkg::mbsrv_state_type d;
   logic [15:0] rdata;
   logic [mbsrv_pkg::AW-1:0] raddr;
   logic [8:0] rd_ofs;

   // Check a complete request; the earliest failing class wins
   function automatic logic [7:0] calc_exc(input logic [7:0] fc, input logic [15:0] a,
                                           input logic [15:0] b, input logic [7:0] bc,
                                           input logic flt);
      logic [16:0] end_addr;
      logic [7:0] ex;
      end_addr = {1'b0, a} + {1'b0, b};
      ex = mbsrv_pkg::EX_NONE;
      if (flt)
      begin
         ex = mbsrv_pkg::EX_FAIL; // see RQ17
      end
      else if (fc == mbsrv_pkg::FC_RD)
      begin
         if (b == 16'h0000 || b > mbsrv_pkg::RD_MAX)
         begin
            ex = mbsrv_pkg::EX_VALUE; // see RQ16
         end
         else if (end_addr > {1'b0, mbsrv_pkg::WO_BASE})
         begin
            ex = mbsrv_pkg::EX_ADDR; // see RQ15 see RQ20
         end
      end
      else if (fc == mbsrv_pkg::FC_WR1)
      begin
         if (a >= mbsrv_pkg::WORDS16 || a < mbsrv_pkg::RO_END)
         begin
            ex = mbsrv_pkg::EX_ADDR; // see RQ15 see RQ20
         end
      end
      else if (fc == mbsrv_pkg::FC_WRN)
      begin
         if (b == 16'h0000 || b > mbsrv_pkg::WRN_MAX || {8'h00, bc} != {b[14:0], 1'b0})
         begin
            ex = mbsrv_pkg::EX_VALUE; // see RQ16
         end
         else if (a < mbsrv_pkg::RO_END || end_addr > {1'b0, mbsrv_pkg::WORDS16})
         begin
            ex = mbsrv_pkg::EX_ADDR; // see RQ15 see RQ20
         end
      end
      else if (fc == mbsrv_pkg::FC_DID)
      begin
         if (a[15:8] != mbsrv_pkg::SUB_DID)
         begin
            ex = mbsrv_pkg::EX_FUNC; // see RQ14
         end
         else if (a[7:0] == 8'h00 || a[7:0] > mbsrv_pkg::DID_CODE_MAX)
         begin
            ex = mbsrv_pkg::EX_VALUE; // see RQ16
         end
      end
      else
      begin
         // Non-adjacent read belongs to a later revision, so it is refused here
         ex = mbsrv_pkg::EX_FUNC; // see RQ7 see RQ14
      end
      return ex;
   endfunction

   // One byte of the serial-line check, reflected polynomial
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ mbsrv_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   mbsrv_mem u_mem (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .we_i(q.we),
      .waddr_i(q.waddr),
      .wdata_i(q.wdata),
      .raddr_i(raddr),
      .rdata_o(rdata)
   );

   // Read words follow the byte count; two bytes per word, high first
   assign rd_ofs = q.tx_idx - mbsrv_pkg::IX_A_L;
   assign raddr = q.a[mbsrv_pkg::AW-1:0] + rd_ofs[mbsrv_pkg::AW:1];

   always_comb
   begin
      logic [8:0] idx;
      logic [7:0] byt;
      logic frame_ok;
      logic [8:0] wofs;
      idx = '0;
      byt = '0;
      frame_ok = 1'b0;
      wofs = '0;
      d = q;
      d.we = 1'b0;
      d.flt = {q.flt[0], fault_i};

      // Transmit side: each byte takes a settle cycle so store data is ready
      if (q.st == mbsrv_pkg::S_TX)
      begin
         if (q.tx.valid && tx_ready_i)
         begin
            d.tx.valid = 1'b0;
            if (q.tx.last)
            begin
               d.st = mbsrv_pkg::S_RX;
            end
         end
         else if (!q.tx.valid && !q.tx_wait)
         begin
            d.tx_wait = 1'b1;
         end
         else if (!q.tx.valid)
         begin
            unique case (q.tx_idx)
               mbsrv_pkg::IX_TID_H: byt = q.tid[15:8]; // see RQ1
               mbsrv_pkg::IX_TID_L: byt = q.tid[7:0]; // see RQ1
               mbsrv_pkg::IX_PID_H: byt = q.pid[15:8]; // see RQ2
               mbsrv_pkg::IX_PID_L: byt = q.pid[7:0]; // see RQ2
               mbsrv_pkg::IX_LEN_H: byt = 8'h00;
               mbsrv_pkg::IX_LEN_L: byt = q.pdu_len + 8'h01; // see RQ3
               mbsrv_pkg::IX_UID: byt = q.uid; // see RQ4 see RQ12
               mbsrv_pkg::IX_FC: byt = (q.exc != mbsrv_pkg::EX_NONE) ? (q.fc | mbsrv_pkg::EXC_FLAG) : q.fc; // see RQ13
               default:
               begin
                  if (q.exc != mbsrv_pkg::EX_NONE)
                  begin
                     // Exception body: code, then the check low byte first
                     unique case (q.tx_idx)
                        mbsrv_pkg::IX_A_H: byt = q.exc; // see RQ11 see RQ12
                        mbsrv_pkg::IX_A_L: byt = q.crc[7:0]; // see RQ12
                        default: byt = q.crc[15:8];
                     endcase
                  end
                  else if (q.fc == mbsrv_pkg::FC_RD)
                  begin
                     if (q.tx_idx == mbsrv_pkg::IX_A_H)
                     begin
                        byt = {q.b[6:0], 1'b0};
                     end
                     else
                     begin
                        byt = rd_ofs[0] ? rdata[7:0] : rdata[15:8]; // see RQ5 see RQ8
                     end
                  end
                  else if (q.fc == mbsrv_pkg::FC_DID)
                  begin
                     unique case (q.tx_idx)
                        mbsrv_pkg::IX_A_H: byt = mbsrv_pkg::SUB_DID; // see RQ6
                        mbsrv_pkg::IX_A_L: byt = q.a[7:0];
                        mbsrv_pkg::IX_B_H: byt = mbsrv_pkg::DID_CONF;
                        9'h00D: byt = mbsrv_pkg::DID_NOBJ;
                        9'h00E: byt = mbsrv_pkg::DID_OBJ0;
                        9'h00F: byt = mbsrv_pkg::DID_OBJLEN;
                        9'h010: byt = ID_CODE;
                        default: byt = 8'h00;
                     endcase
                  end
                  else
                  begin
                     // Single and multiple writes echo address and value or quantity
                     unique case (q.tx_idx)
                        mbsrv_pkg::IX_A_H: byt = q.a[15:8]; // see RQ8
                        mbsrv_pkg::IX_A_L: byt = q.a[7:0];
                        mbsrv_pkg::IX_B_H: byt = q.b[15:8];
                        default: byt = q.b[7:0];
                     endcase
                  end
               end
            endcase
            d.tx.valid = 1'b1;
            d.tx.data = byt;
            d.tx.last = (q.tx_idx == {1'b0, q.pdu_len} + mbsrv_pkg::IX_UID);
            d.tx_idx = q.tx_idx + 9'h001;
            d.tx_wait = 1'b0;
            if (q.tx_idx >= mbsrv_pkg::IX_UID && q.tx_idx <= mbsrv_pkg::IX_A_H)
            begin
               d.crc = crc_step(q.crc, byt); // see RQ12
            end
         end
      end

      // Queued busy answer goes out once the slot frees, also when its frame ended late
      if (q.b_pend && d.st == mbsrv_pkg::S_RX)
      begin
         d.st = mbsrv_pkg::S_TX;
         d.tid = q.b_tid;
         d.pid = q.b_pid;
         d.uid = q.b_uid;
         d.fc = q.b_fc;
         d.exc = mbsrv_pkg::EX_BUSY; // see RQ18 see RQ21
         d.pdu_len = mbsrv_pkg::PDU_EXC;
         d.tx_idx = '0;
         d.tx_wait = 1'b0;
         d.crc = mbsrv_pkg::CRC_INIT;
         d.b_pend = 1'b0;
      end

      // Receive side runs at all times; a frame that starts mid-answer is busy, or dropped if a busy answer already waits
      if (rx_i.valid)
      begin
         idx = q.rx_on ? q.rx_idx : 9'h000;
         if (!q.rx_on)
         begin
            d.rx_bad = 1'b0;
            if (d.st == mbsrv_pkg::S_RX)
            begin
               d.rxm = mbsrv_pkg::M_NORM;
            end
            else
            begin
               // Only one busy answer can wait; later frames are dropped
               d.rxm = q.b_pend ? mbsrv_pkg::M_DROP : mbsrv_pkg::M_BUSY; // see RQ21
            end
         end
         d.rx_on = !rx_i.last;
         d.rx_idx = (idx == mbsrv_pkg::IX_MAX) ? idx : idx + 9'h001;
         if (rx_i.err)
         begin
            d.rx_bad = 1'b1;
         end
         if (d.rxm == mbsrv_pkg::M_BUSY)
         begin
            unique case (idx)
               mbsrv_pkg::IX_TID_H: d.b_tid[15:8] = rx_i.data;
               mbsrv_pkg::IX_TID_L: d.b_tid[7:0] = rx_i.data;
               mbsrv_pkg::IX_PID_H: d.b_pid[15:8] = rx_i.data;
               mbsrv_pkg::IX_PID_L: d.b_pid[7:0] = rx_i.data;
               mbsrv_pkg::IX_LEN_H: d.len[15:8] = rx_i.data;
               mbsrv_pkg::IX_LEN_L: d.len[7:0] = rx_i.data;
               mbsrv_pkg::IX_UID: d.b_uid = rx_i.data;
               mbsrv_pkg::IX_FC: d.b_fc = rx_i.data;
               default: ;
            endcase
         end
         else if (d.rxm == mbsrv_pkg::M_NORM)
         begin
            unique case (idx)
               mbsrv_pkg::IX_TID_H: d.tid[15:8] = rx_i.data;
               mbsrv_pkg::IX_TID_L: d.tid[7:0] = rx_i.data;
               mbsrv_pkg::IX_PID_H: d.pid[15:8] = rx_i.data;
               mbsrv_pkg::IX_PID_L: d.pid[7:0] = rx_i.data;
               mbsrv_pkg::IX_LEN_H: d.len[15:8] = rx_i.data;
               mbsrv_pkg::IX_LEN_L: d.len[7:0] = rx_i.data;
               mbsrv_pkg::IX_UID: d.uid = rx_i.data;
               mbsrv_pkg::IX_FC: d.fc = rx_i.data;
               mbsrv_pkg::IX_A_H: d.a[15:8] = rx_i.data;
               mbsrv_pkg::IX_A_L: d.a[7:0] = rx_i.data;
               mbsrv_pkg::IX_B_H: d.b[15:8] = rx_i.data;
               mbsrv_pkg::IX_B_L: d.b[7:0] = rx_i.data;
               mbsrv_pkg::IX_BC:
               begin
                  d.bc = rx_i.data;
                  // Multiple-word data is stored as it streams, so it is checked up front
                  d.wok = (q.fc == mbsrv_pkg::FC_WRN) && !q.rx_bad && !rx_i.err
                          && (calc_exc(q.fc, q.a, q.b, rx_i.data, q.flt[1]) == mbsrv_pkg::EX_NONE); // see RQ20
               end
               default:
               begin
                  if (idx[0])
                  begin
                     d.hold = rx_i.data;
                  end
                  else
                  begin
                     wofs = idx - mbsrv_pkg::IX_DATA;
                     d.we = q.wok && !rx_i.err; // see RQ5
                     d.waddr = q.a[mbsrv_pkg::AW-1:0] + wofs[mbsrv_pkg::AW:1];
                     d.wdata = {q.hold, rx_i.data};
                  end
               end
            endcase
         end

         if (rx_i.last)
         begin
            // Damaged, truncated or length-inconsistent frames are silently dropped
            frame_ok = !q.rx_bad && !rx_i.err && idx >= mbsrv_pkg::IX_FC
                       && ({7'h00, idx} == d.len + mbsrv_pkg::LEN_OFS); // see RQ9
            d.wok = 1'b0;
            if (frame_ok && d.rxm == mbsrv_pkg::M_BUSY)
            begin
               d.b_pend = 1'b1; // see RQ18 see RQ21
            end
            else if (frame_ok && d.rxm == mbsrv_pkg::M_NORM)
            begin
               d.exc = calc_exc(d.fc, d.a, d.b, d.bc, q.flt[1]); // see RQ11
               d.st = mbsrv_pkg::S_TX;
               d.tx_idx = '0;
               d.tx_wait = 1'b0;
               d.crc = mbsrv_pkg::CRC_INIT;
               if (d.exc != mbsrv_pkg::EX_NONE)
               begin
                  d.pdu_len = mbsrv_pkg::PDU_EXC;
               end
               else if (d.fc == mbsrv_pkg::FC_RD)
               begin
                  d.pdu_len = mbsrv_pkg::PDU_RD_FIX + {d.b[6:0], 1'b0};
               end
               else if (d.fc == mbsrv_pkg::FC_DID)
               begin
                  d.pdu_len = mbsrv_pkg::PDU_DID;
               end
               else
               begin
                  d.pdu_len = mbsrv_pkg::PDU_ECHO;
               end
               if (d.exc == mbsrv_pkg::EX_NONE && d.fc == mbsrv_pkg::FC_WR1)
               begin
                  d.we = 1'b1; // see RQ5 see RQ8
                  d.waddr = d.a[mbsrv_pkg::AW-1:0];
                  d.wdata = d.b;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tx_o = q.tx;

endmodule
`default_nettype wire

// ==== verif/mbsrv_props.sv ====
// Port checker for the request server
`timescale 1ns/10ps
`default_nettype none
module mbsrv_props
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Streams and fault
   input wire mbsrv_pkg::mbsrv_rx_type rx_i,
   input wire mbsrv_pkg::mbsrv_tx_type tx_o,
   input wire logic tx_ready_i,
   input wire logic fault_i
);
   logic [8:0] ridx;
   logic [8:0] tidx;
   logic [15:0] rlen;
   logic [15:0] tlen;
   logic [7:0] ruid;
   logic [7:0] auid;
   logic [3:0] quiet;
   logic rbad;
   logic texc;
   logic first;
   wire logic rend = rx_i.valid && rx_i.last;
   wire logic tgo = tx_o.valid && tx_ready_i;
   wire logic rgood = !rbad && !rx_i.err && ridx > 9'h006 && {7'h00, ridx} == rlen + 16'h0005;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Quiet means nothing is left over, so a fresh frame owns the next answer
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ridx <= 9'h000;
         tidx <= 9'h000;
         rbad <= 1'b0;
         quiet <= 4'h0;
         first <= 1'b0;
      end
      else
      begin
         ridx <= rend ? 9'h000 : ridx + {8'h00, rx_i.valid};
         rbad <= rend ? 1'b0 : rbad | (rx_i.valid & rx_i.err);
         tidx <= tgo ? (tx_o.last ? 9'h000 : tidx + 9'h001) : tidx;
         quiet <= tx_o.valid ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
         first <= (rend && quiet == 4'hF && rgood) || (first && !(tgo && tx_o.last));
      end
      if (rx_i.valid && ridx == 9'h004) rlen[15:8] <= rx_i.data;
      if (rx_i.valid && ridx == 9'h005) rlen[7:0] <= rx_i.data;
      if (rx_i.valid && ridx == 9'h006) ruid <= rx_i.data;
      if (rend && quiet == 4'hF) auid <= ruid;
      if (tgo && tidx == 9'h004) tlen[15:8] <= tx_o.data;
      if (tgo && tidx == 9'h005) tlen[7:0] <= tx_o.data;
      if (tgo && tidx == 9'h007) texc <= tx_o.data[7];
   end
   reset_a: assert property ($rose(rst_n_i) |-> !tx_o.valid)
      else $error("response byte right after reset");
   hold_a: assert property (tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data) && $stable(tx_o.last))
      else $error("response byte changed before it was taken");
   answer_a: assert property (rend && quiet == 4'hF && rgood |-> ##3 tx_o.valid)
      else $error("clean request got no answer in time");
   drop_a: assert property (rend && quiet == 4'hF && (rbad || rx_i.err) |-> ##1 !tx_o.valid [*8])
      else $error("answer to a damaged request");
   uid_echo_a: assert property (tx_o.valid && first && tidx == 9'h006 |-> tx_o.data == auid)
      else $error("unit identifier not echoed");
   len_field_a: assert property (tx_o.valid && tx_o.last |-> {7'h00, tidx} == tlen + 16'h0005)
      else $error("length field disagrees with bytes sent");
   exc_code_a: assert property (tx_o.valid && texc && tidx == 9'h008 |-> tx_o.data inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06})
      else $error("exception code outside the defined set");
   exc_size_a: assert property (tx_o.valid && texc && tidx > 9'h007 |-> tx_o.last == (tidx == 9'h00A))
      else $error("exception frame of wrong size");
   answer_c: cover property (rend && rgood ##3 tx_o.valid);
   busy_c: cover property (tx_o.valid && texc && tidx == 9'h008 && tx_o.data == 8'h06);
   drop_c: cover property (rend && rbad);
endmodule
`default_nettype wire

// ==== verif/mbsrv_client.sv ====
// Behavioural client on the far side of the request server
`timescale 1ns/10ps
`default_nettype none
module mbsrv_client
(
   // Clock
   input wire logic clk_i,
   // Request stream to the server
   output var mbsrv_pkg::mbsrv_rx_type rx_o,
   // Response stream from the server
   input wire mbsrv_pkg::mbsrv_tx_type tx_i,
   output var logic tx_ready_o,
   // Slow mode: one byte taken in sixteen cycles
   input wire logic stall_i
);
   typedef logic [7:0] mbsrv_bq_type[$];
   mbsrv_bq_type got;
   logic [3:0] cnt = 4'h0;
   initial rx_o = '0;
   task automatic send(input mbsrv_bq_type f, input int bad);
      foreach (f[i])
      begin
         @(negedge clk_i);
         rx_o <= {1'b1, f[i], i == f.size() - 1, i == bad};
      end
      @(negedge clk_i);
      // Idle line shows the inverse so a stale byte never looks fresh
      rx_o <= {1'b0, ~f[f.size() - 1], 2'b00};
   endtask
   // Give up on a request that stays unanswered
   task automatic take(input int n, output logic ok);
      int t;
      t = 0;
      while (got.size() < n && t < 3000)
      begin
         @(posedge clk_i);
         t++;
      end
      ok = got.size() >= n;
   endtask
   always @(negedge clk_i)
   begin
      cnt <= cnt + 4'h1;
      tx_ready_o <= !stall_i || cnt == 4'h0;
   end
   always @(posedge clk_i)
      if (tx_i.valid && tx_ready_o) got.push_back(tx_i.data);
endmodule
`default_nettype wire

// ==== verif/mbsrv_test.sv ====
// Self-checking testbench for the request server
`timescale 1ns/10ps
`default_nettype none
bind mbsrv_top mbsrv_props mbsrv_props_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_i(rx_i), .tx_o(tx_o),
   .tx_ready_i(tx_ready_i), .fault_i(fault_i));
module mbsrv_test;
   typedef logic [7:0] mbsrv_bq_type[$];
   // Identification byte, arbitrary value
   localparam logic [7:0] ID = 8'h3C;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fault = 1'b0;
   logic stall = 1'b0;
   logic rdy;
   mbsrv_pkg::mbsrv_rx_type rx;
   mbsrv_pkg::mbsrv_tx_type tx;
   int n_mismatch = 0;
   int n_tests = 0;
   always #50 clk = ~clk;
   mbsrv_top #(.ID_CODE(ID)) mbsrv_top_i (.clk_i(clk), .rst_n_i(rst_n), .rx_i(rx), .tx_o(tx),
      .tx_ready_i(rdy), .fault_i(fault));
   mbsrv_client mbsrv_client_i (.clk_i(clk), .rx_o(rx), .tx_i(tx), .tx_ready_o(rdy), .stall_i(stall));
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   function automatic mbsrv_bq_type frame(input logic [15:0] tid, input logic [7:0] uid, fc,
                                          input logic [79:0] p, input int np);
      logic [15:0] len;
      len = 16'(np + 2);
      frame = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], uid, fc};
      for (int i = 0; i < np; i++) frame = {frame, p[8 * (np - 1 - i) +: 8]};
   endfunction
   // Exceptions carry two check bytes beyond the listed ones
   task automatic judge(input int o, input logic [15:0] tid, input logic [7:0] uid, input logic [79:0] e,
                        input int ne);
      mbsrv_bq_type g;
      g = mbsrv_client_i.got;
      cmp({g[o], g[o + 1]}, tid);
      cmp({g[o + 2], g[o + 3]}, 16'h0000);
      cmp({g[o + 4], g[o + 5]}, 16'(ne + ((ne == 2) ? 3 : 1)));
      cmp({8'h00, g[o + 6]}, {8'h00, uid});
      for (int i = 0; i < ne; i++) cmp({8'h00, g[o + 7 + i]}, {8'h00, e[8 * (ne - 1 - i) +: 8]});
   endtask
   task automatic xact(input logic [15:0] tid, input logic [7:0] uid, fc, input logic [79:0] p,
                       input int np, bad, input logic [79:0] e, input int ne);
      logic ok;
      int n;
      n = (ne == 0) ? 0 : 7 + ne + ((ne == 2) ? 2 : 0);
      mbsrv_client_i.got.delete();
      mbsrv_client_i.send(frame(tid, uid, fc, p, np), bad);
      if (n > 0)
      begin
         mbsrv_client_i.take(n, ok);
         cmp({15'h0000, ok}, 16'h0001);
         judge(0, tid, uid, e, ne);
      end
      repeat ((n > 0) ? 20 : 200) @(negedge clk);
      cmp(16'(mbsrv_client_i.got.size()), 16'(n));
   endtask
   task automatic t_rw;
      xact(16'h1201, 8'h11, 8'h06, 32'h0020BEEF, 4, -1, 40'h060020BEEF, 5);
      xact(16'hA55A, 8'hF7, 8'h03, 32'h00200001, 4, -1, 32'h0302BEEF, 4);
      $display("t_rw done");
   endtask
   task automatic t_multi;
      xact(16'h3003, 8'h22, 8'h10, 72'h002E00020412345678, 9, -1, 40'h10002E0002, 5);
      xact(16'h3004, 8'h22, 8'h03, 32'h002F0001, 4, -1, 32'h03025678, 4);
      xact(16'h3005, 8'h23, 8'h2B, 24'h0E0100, 3, -1, {72'h2B0E01010000010001, ID}, 10);
      $display("t_multi done");
   endtask
   task automatic t_exc;
      xact(16'h4001, 8'h31, 8'h06, 32'h000F1234, 4, -1, 16'h8602, 2);
      xact(16'h4002, 8'h31, 8'h03, 32'h00300001, 4, -1, 16'h8302, 2);
      xact(16'h4003, 8'h31, 8'h03, 32'h00200000, 4, -1, 16'h8303, 2);
      xact(16'h4004, 8'h31, 8'h03, 32'h0020007E, 4, -1, 16'h8303, 2);
      xact(16'h4005, 8'h31, 8'h10, 64'h0020000203010203, 8, -1, 16'h9003, 2);
      xact(16'h4006, 8'h31, 8'h64, 32'h04010020, 4, -1, 16'hE401, 2);
      xact(16'h4007, 8'h31, 8'h2B, 24'h0D0100, 3, -1, 16'hAB01, 2);
      $display("t_exc done");
   endtask
   task automatic t_err;
      xact(16'h5001, 8'h41, 8'h03, 32'h00200001, 4, 5, 0, 0);
      xact(16'h5002, 8'h41, 8'h03, 32'h00200001, 4, 11, 0, 0);
      $display("t_err done");
   endtask
   task automatic t_fault;
      fault = 1'b1;
      repeat (4) @(negedge clk);
      xact(16'h6001, 8'h51, 8'h03, 32'h00200001, 4, -1, 16'h8304, 2);
      fault = 1'b0;
      repeat (4) @(negedge clk);
      $display("t_fault done");
   endtask
   task automatic t_busy;
      logic ok;
      stall = 1'b1;
      mbsrv_client_i.got.delete();
      mbsrv_client_i.send(frame(16'h7001, 8'h61, 8'h03, 32'h00200001, 4), -1);
      mbsrv_client_i.send(frame(16'h7002, 8'h62, 8'h03, 32'h00200001, 4), -1);
      mbsrv_client_i.take(22, ok);
      cmp({15'h0000, ok}, 16'h0001);
      judge(0, 16'h7001, 8'h61, 32'h0302BEEF, 4);
      judge(11, 16'h7002, 8'h62, 16'h8306, 2);
      stall = 1'b0;
      xact(16'h7002, 8'h62, 8'h03, 32'h00200001, 4, -1, 32'h0302BEEF, 4);
      $display("t_busy done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_rw();
      t_multi();
      t_exc();
      t_err();
      t_fault();
      t_busy();
      end_of_test();
   end
   // The tests need about 2000 cycles; fifteen times that means a hang
   initial
   begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
